/* common/sra_pkg.sv */
// ****************************************************************
// Constants shared by the serial register access block.
// ****************************************************************
package sra_pkg;

    localparam logic [4:0]  ADDR_NOP         = 5'h00;
    localparam logic [4:0]  ADDR_OUT_DATA    = 5'h02;
    localparam logic [4:0]  ADDR_SW_LOAD     = 5'h07;
    localparam logic [4:0]  ADDR_KEY         = 5'h08;
    localparam logic [4:0]  ADDR_GP_CONFIG1  = 5'h09;
    localparam logic [4:0]  ADDR_DIAG_CONFIG = 5'h10;
    localparam logic [4:0]  ADDR_RB_SELECT   = 5'h13;
    localparam logic [4:0]  ADDR_DIAG_FLAGS  = 5'h14;
    localparam logic [4:0]  ADDR_STATUS      = 5'h16;
    localparam logic [4:0]  ADDR_CHIP_ID     = 5'h17;
    localparam logic [4:0]  ADDR_FREQ_MON    = 5'h18;
    localparam logic [4:0]  ADDR_DEVICE_ID   = 5'h1C;

    localparam logic [15:0] RST_GP_CONFIG1   = 16'h0204;
    localparam logic [15:0] RST_DIAG_CONFIG  = 16'h005D;
    localparam logic [15:0] RST_RB_SELECT    = 16'h0000;
    localparam logic [15:0] RST_DIAG_FLAGS   = 16'hA000;

    localparam int          OSC_EN_BIT       = 2;
    localparam int          CRC_EN_BIT       = 0;
    localparam int          RB_MODE_LSB      = 8;
    localparam int          FLAG_PENDING     = 15;
    localparam int          FLAG_INVALID     = 5;
    localparam int          FLAG_COUNT       = 4;
    localparam int          FLAG_CRC         = 3;
    localparam int          FLAG_SLIP        = 2;

    localparam logic [5:0]  LEN_SHORT        = 6'd24;
    localparam logic [5:0]  LEN_LONG         = 6'd32;
    localparam logic [5:0]  LEN_MAX          = 6'h3F;
    localparam logic [15:0] KEY_REFRESH      = 16'hFCBA;
    localparam logic [23:0] OSC_HALT_CODE    = 24'h07DEAD;
    localparam logic [7:0]  CRC_POLY         = 8'h07;
    localparam logic [1:0]  SYNC_PATTERN     = 2'b10;

    typedef enum logic [1:0] {
        RB_TWO_STAGE,
        RB_AUTO,
        RB_SHARED_AUTO,
        RB_ECHO
    } sra_rb_mode_t;

    typedef enum {
        FR_IDLE,
        FR_ACTIVE,
        FR_DECODE
    } sra_frame_state_t;

    function automatic logic [7:0] crc8(input logic [23:0] data);
        logic [7:0] c;
        logic       fb;
        c = 8'h00;
        for (int i = 23; i >= 0; i--) begin
            fb = c[7] ^ data[i];
            c  = {c[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
        end
        return c;
    endfunction : crc8

    function automatic logic is_reserved(input logic [4:0] addr);
        return (addr >= 5'h0B && addr <= 5'h0F) || addr == 5'h11 ||
               (addr >= 5'h19 && addr <= 5'h1B) || addr >= 5'h1D;
    endfunction : is_reserved

    function automatic logic is_read_only(input logic [4:0] addr);
        return addr == ADDR_OUT_DATA || addr == ADDR_STATUS ||
               addr == ADDR_CHIP_ID || addr == ADDR_FREQ_MON ||
               addr == ADDR_DEVICE_ID;
    endfunction : is_read_only

endpackage : sra_pkg

/* common/sra_mem_if.sv */
`timescale 1ns/1ns
// ****************************************************************
// Register store access between the frame logic and the memory.
// ****************************************************************
interface sra_mem_if;
    logic        wr_en;
    logic [4:0]  wr_addr;
    logic [15:0] wr_data;
    logic [4:0]  rd_addr;
    logic [15:0] rd_data;

    modport ctrl (
        output wr_en,
        output wr_addr,
        output wr_data,
        output rd_addr,
        input  rd_data
    );

    modport store (
        input  wr_en,
        input  wr_addr,
        input  wr_data,
        input  rd_addr,
        output rd_data
    );
endinterface : sra_mem_if

/* core/sra_reg_mem.sv */
`timescale 1ns/1ns
// ****************************************************************
// Generic register store, 32 words of 16 bits.
// ****************************************************************
module sra_reg_mem (
    input  wire logic clk,
    input  wire logic rst_n,
    sra_mem_if.store  mem
);
    logic [15:0] words [32];

    // Cleared on reset so that readback of untouched words is defined.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int i = 0; i < 32; i++) begin
                words[i] <= 16'h0000;
            end
        end else if (mem.wr_en) begin
            words[mem.wr_addr] <= mem.wr_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mem.rd_data <= 16'h0000;
        end else begin
            mem.rd_data <= words[mem.rd_addr];
        end
    end
endmodule : sra_reg_mem

/* core/sra_serial_regs.sv */
`timescale 1ns/1ns
// Contract
// - Access to a reserved register address raises the invalid access flag.
// - CRC on from reset; frames must then be exactly 32 bits.
// - With CRC off, 24-bit and 32-bit frames accepted, extra byte ignored.
// - Frame: slip bit, two address bits, five register bits, sixteen data.
// - Frame acted on only when address bits match the address pins.
// - Register address bits 20 to 16 select the written register.
// - Four readback modes chosen by the mode field of readback select.
// - Two-stage: select a register, next frame shifts out its contents.
// - New readback request during return frame answered in next frame.
// - Readback frame: sync 10, fault state, address, sixteen data bits.
// - Autostatus returns the status word on every frame.
// - Shared mode flag set by valid write, cleared on frame-select fall.
// - Shared mode drives output only in a frame begun with the valid-write flag set.
// - Echo mode returns the previous command on every second frame.
// - Key 0xFCBA starts calibration refresh; pending flag shows progress.
// - Writing one to a sticky flag reloads it with the current fault.
// - Halted oscillator returns fixed code 0x07DEAD unless disabled.
module sra_serial_regs (
    input  wire logic        CLK,
    input  wire logic        RST_N,
    input  wire logic        SCLK,
    input  wire logic        SYNC_N,
    input  wire logic        SDI,
    input  wire logic        DEVICE_ADDR_HI,
    input  wire logic        DEVICE_ADDR_LO,
    input  wire logic        FAULT_N,
    input  wire logic        OSC_HALTED,
    input  wire logic [15:0] DIG_FAULT_IN,
    input  wire logic        ANALOG_FAULT_SUMMARY,
    input  wire logic        CALIB_DONE,
    output logic             SDO,
    output logic             SDO_OE,
    output logic             WR_STROBE,
    output logic [4:0]       WR_ADDR,
    output logic [15:0]      WR_DATA,
    output logic             CALIB_REFRESH_REQ,
    output logic             LOAD_OUTPUT_STROBE,
    output logic [15:0]      DIGITAL_DIAG_FLAGS
);
    // ************************************************************
    // Pin synchronisers and edge detection
    // ************************************************************
    logic       sclk_s1;
    logic       sclk_s2;
    logic       sclk_s3;
    logic       sync_s1;
    logic       sync_s2;
    logic       sync_s3;
    logic       sdi_s1;
    logic       sdi_s2;
    logic       ahi_s1;
    logic       ahi_s2;
    logic       alo_s1;
    logic       alo_s2;
    logic       fault_s1;
    logic       fault_s2;
    logic       osc_s1;
    logic       osc_s2;
    logic       sclk_fall;
    logic       sync_fall;
    logic       sync_rise;

    // The serial clock is slow against CLK, so edges are found by
    // sampling rather than by clocking logic on the pin itself.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            sclk_s1  <= 1'b0;
            sclk_s2  <= 1'b0;
            sclk_s3  <= 1'b0;
            sync_s1  <= 1'b1;
            sync_s2  <= 1'b1;
            sync_s3  <= 1'b1;
            sdi_s1   <= 1'b0;
            sdi_s2   <= 1'b0;
            ahi_s1   <= 1'b0;
            ahi_s2   <= 1'b0;
            alo_s1   <= 1'b0;
            alo_s2   <= 1'b0;
            fault_s1 <= 1'b1;
            fault_s2 <= 1'b1;
            osc_s1   <= 1'b0;
            osc_s2   <= 1'b0;
        end else begin
            sclk_s1  <= SCLK;
            sclk_s2  <= sclk_s1;
            sclk_s3  <= sclk_s2;
            sync_s1  <= SYNC_N;
            sync_s2  <= sync_s1;
            sync_s3  <= sync_s2;
            sdi_s1   <= SDI;
            sdi_s2   <= sdi_s1;
            ahi_s1   <= DEVICE_ADDR_HI;
            ahi_s2   <= ahi_s1;
            alo_s1   <= DEVICE_ADDR_LO;
            alo_s2   <= alo_s1;
            fault_s1 <= FAULT_N;
            fault_s2 <= fault_s1;
            osc_s1   <= OSC_HALTED;
            osc_s2   <= osc_s1;
        end
    end

    assign sclk_fall = sclk_s3 & ~sclk_s2;
    assign sync_fall = sync_s3 & ~sync_s2;
    assign sync_rise = ~sync_s3 & sync_s2;

    // ************************************************************
    // Frame state, shift in and bit count
    // ************************************************************
    sra_pkg::sra_frame_state_t state;
    logic [31:0] rx_shift;
    logic [5:0]  bit_count;

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            state <= sra_pkg::FR_IDLE;
        end else begin
            case (state)
                sra_pkg::FR_IDLE: begin
                    if (sync_fall) begin
                        state <= sra_pkg::FR_ACTIVE;
                    end
                end
                sra_pkg::FR_ACTIVE: begin
                    if (sync_rise) begin
                        state <= sra_pkg::FR_DECODE;
                    end
                end
                sra_pkg::FR_DECODE: begin
                    state <= sra_pkg::FR_IDLE;
                end
                default: begin
                    state <= sra_pkg::FR_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            rx_shift  <= 32'h0000_0000;
            bit_count <= 6'h00;
        end else if (sync_fall) begin
            bit_count <= 6'h00;
        end else if (state == sra_pkg::FR_ACTIVE && sclk_fall) begin
            rx_shift <= {rx_shift[30:0], sdi_s2};
            if (bit_count != sra_pkg::LEN_MAX) begin
                bit_count <= bit_count + 6'h01;
            end
        end
    end

    // ************************************************************
    // Command decode at the end of a frame
    // ************************************************************
    logic [15:0] gp_config1;
    logic [15:0] diag_config;
    logic [15:0] rb_select;
    logic [15:0] diag_flags;
    logic        crc_en;
    logic        long_frame;
    logic [23:0] cmd_word;
    logic        len_ok;
    logic        crc_ok;
    logic        slip_ok;
    logic        addr_ok;
    logic        accepted;
    logic        bad_addr;
    logic        good_write;
    logic [4:0]  cmd_addr;
    logic [15:0] cmd_data;
    logic        decoding;

    assign crc_en     = diag_config[sra_pkg::CRC_EN_BIT];
    assign decoding   = (state == sra_pkg::FR_DECODE);
    assign long_frame = (bit_count == sra_pkg::LEN_LONG);
    // A 32-bit frame with CRC off still has its command in the top bytes.
    assign cmd_word   = long_frame ? rx_shift[31:8] : rx_shift[23:0];
    assign cmd_addr   = cmd_word[20:16];
    assign cmd_data   = cmd_word[15:0];
    assign len_ok     = crc_en ? long_frame
                      : (long_frame || bit_count == sra_pkg::LEN_SHORT);
    assign crc_ok     = !crc_en ||
                        rx_shift[7:0] == sra_pkg::crc8(rx_shift[31:8]);
    assign slip_ok    = cmd_word[23] == ~cmd_word[22];
    assign addr_ok    = cmd_word[22] == ahi_s2 &&
                        cmd_word[21] == alo_s2;
    assign accepted   = decoding & len_ok & crc_ok & slip_ok & addr_ok;
    assign bad_addr   = sra_pkg::is_reserved(cmd_addr);
    assign good_write = accepted & ~bad_addr;

    // ************************************************************
    // Error events
    // ************************************************************
    logic        ev_count;
    logic        ev_crc;
    logic        ev_slip;
    logic        ev_invalid;
    logic [1:0]  rb_mode;

    assign rb_mode = rb_select[sra_pkg::RB_MODE_LSB +: 2];

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            ev_count   <= 1'b0;
            ev_crc     <= 1'b0;
            ev_slip    <= 1'b0;
            ev_invalid <= 1'b0;
        end else begin
            ev_count   <= decoding & ~len_ok;
            ev_crc     <= decoding & len_ok & ~crc_ok;
            ev_slip    <= decoding & len_ok & crc_ok & ~slip_ok;
            // A reserved register named for two-stage readback is a read.
            ev_invalid <= (accepted & bad_addr) |
                          (sync_fall &&
                           rb_mode == sra_pkg::RB_TWO_STAGE &&
                           sra_pkg::is_reserved(rb_select[4:0]));
        end
    end

    // ************************************************************
    // Registers held in the frame logic
    // ************************************************************
    logic        wr_here;
    logic [15:0] flag_set;
    logic [15:0] flag_w1;
    logic        key_hit;

    assign wr_here  = good_write && !sra_pkg::is_read_only(cmd_addr);
    assign flag_set = DIG_FAULT_IN |
                      ({15'h0000, ev_invalid} << sra_pkg::FLAG_INVALID) |
                      ({15'h0000, ev_count} << sra_pkg::FLAG_COUNT) |
                      ({15'h0000, ev_crc} << sra_pkg::FLAG_CRC) |
                      ({15'h0000, ev_slip} << sra_pkg::FLAG_SLIP);
    assign flag_w1  = (wr_here && cmd_addr == sra_pkg::ADDR_DIAG_FLAGS)
                      ? cmd_data : 16'h0000;
    assign key_hit  = good_write && cmd_addr == sra_pkg::ADDR_KEY &&
                      cmd_data == sra_pkg::KEY_REFRESH;

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            gp_config1  <= sra_pkg::RST_GP_CONFIG1;
            diag_config <= sra_pkg::RST_DIAG_CONFIG;
            rb_select   <= sra_pkg::RST_RB_SELECT;
        end else if (wr_here) begin
            case (cmd_addr)
                sra_pkg::ADDR_GP_CONFIG1:  gp_config1  <= cmd_data;
                sra_pkg::ADDR_DIAG_CONFIG: diag_config <= cmd_data;
                sra_pkg::ADDR_RB_SELECT:   rb_select   <= cmd_data;
                default: begin
                end
            endcase
        end
    end

    // Writing a one drops the bit but the current fault sets it again in
    // the same cycle, so a persisting fault keeps its flag.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            diag_flags <= sra_pkg::RST_DIAG_FLAGS;
        end else begin
            diag_flags <= (diag_flags & ~flag_w1) | flag_set;
            if (key_hit) begin
                diag_flags[sra_pkg::FLAG_PENDING] <= 1'b1;
            end else if (CALIB_DONE) begin
                diag_flags[sra_pkg::FLAG_PENDING] <= 1'b0;
            end else begin
                diag_flags[sra_pkg::FLAG_PENDING] <=
                    diag_flags[sra_pkg::FLAG_PENDING];
            end
        end
    end

    // ************************************************************
    // Command outputs and register store
    // ************************************************************
    sra_mem_if mem_bus ();

    assign mem_bus.wr_en   = wr_here;
    assign mem_bus.wr_addr = cmd_addr;
    assign mem_bus.wr_data = cmd_data;
    assign mem_bus.rd_addr = rb_select[4:0];

    sra_reg_mem u_mem (
        .clk   (CLK),
        .rst_n (RST_N),
        .mem   (mem_bus.store)
    );

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            WR_STROBE          <= 1'b0;
            WR_ADDR            <= 5'h00;
            WR_DATA            <= 16'h0000;
            CALIB_REFRESH_REQ  <= 1'b0;
            LOAD_OUTPUT_STROBE <= 1'b0;
            DIGITAL_DIAG_FLAGS <= sra_pkg::RST_DIAG_FLAGS;
        end else begin
            WR_STROBE          <= good_write;
            if (good_write) begin
                WR_ADDR <= cmd_addr;
                WR_DATA <= cmd_data;
            end
            CALIB_REFRESH_REQ  <= key_hit;
            LOAD_OUTPUT_STROBE <= good_write &&
                                  cmd_addr == sra_pkg::ADDR_SW_LOAD;
            DIGITAL_DIAG_FLAGS <= diag_flags;
        end
    end

    // ************************************************************
    // Readback modes and shift out
    // ************************************************************
    logic        shared_flag;
    logic        echo_phase;
    logic [23:0] last_cmd;
    logic [31:0] tx_shift;
    logic        drive_en;
    logic        fault_state;
    logic        dig_sum;
    logic [15:0] rb_value;
    logic [23:0] status_word;
    logic [23:0] next_word;

    assign fault_state = ~fault_s2;
    assign dig_sum     = |diag_flags;
    assign status_word = {2'b10, fault_state, dig_sum,
                          ANALOG_FAULT_SUMMARY, 19'h00000};

    always_comb begin
        case (rb_select[4:0])
            sra_pkg::ADDR_NOP:         rb_value = 16'h0000;
            sra_pkg::ADDR_GP_CONFIG1:  rb_value = gp_config1;
            sra_pkg::ADDR_DIAG_CONFIG: rb_value = diag_config;
            sra_pkg::ADDR_RB_SELECT:   rb_value = rb_select;
            sra_pkg::ADDR_DIAG_FLAGS:  rb_value = diag_flags;
            default:                   rb_value = mem_bus.rd_data;
        endcase
    end

    always_comb begin
        if (osc_s2 && gp_config1[sra_pkg::OSC_EN_BIT]) begin
            next_word = sra_pkg::OSC_HALT_CODE;
        end else begin
            case (rb_mode)
                sra_pkg::RB_TWO_STAGE: next_word =
                    {sra_pkg::SYNC_PATTERN, fault_state,
                     rb_select[4:0], rb_value};
                sra_pkg::RB_ECHO: next_word = echo_phase
                    ? last_cmd : status_word;
                default: next_word = status_word;
            endcase
        end
    end

    // The select written in one frame steers the very next frame.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            tx_shift <= 32'h0000_0000;
        end else if (sync_fall) begin
            tx_shift <= {next_word,
                         crc_en ? sra_pkg::crc8(next_word) : 8'h00};
        end else if (state == sra_pkg::FR_ACTIVE && sclk_fall) begin
            tx_shift <= {tx_shift[30:0], 1'b0};
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            shared_flag <= 1'b0;
        end else if (good_write) begin
            shared_flag <= 1'b1;
        end else if (sync_fall) begin
            shared_flag <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            echo_phase <= 1'b0;
            last_cmd   <= 24'h000000;
        end else begin
            if (sync_fall && rb_mode == sra_pkg::RB_ECHO) begin
                echo_phase <= ~echo_phase;
            end
            if (accepted) begin
                last_cmd <= cmd_word;
            end
        end
    end

    // Flag is sampled at the select fall, before the clear takes effect.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            drive_en <= 1'b0;
        end else if (sync_fall) begin
            drive_en <= rb_mode != sra_pkg::RB_SHARED_AUTO ||
                        shared_flag;
        end else if (sync_rise) begin
            drive_en <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            SDO    <= 1'b0;
            SDO_OE <= 1'b0;
        end else begin
            SDO    <= tx_shift[31];
            SDO_OE <= drive_en & ~sync_s2;
        end
    end
endmodule : sra_serial_regs

/* dv/sra_host_model.sv */
`timescale 1ns/1ns
// ************************************************************
// Host side of the serial link: frames, clock and data out.
// ************************************************************
module sra_host_model (
    input  wire logic clk,
    input  wire logic sdo,
    input  wire logic sdo_oe,
    output logic      sclk,
    output logic      sync_n,
    output logic      sdi
);
    logic oe = 1'h0;
    initial begin
        sclk = 1'h1;
        sync_n = 1'h1;
        sdi = 1'h0;
    end
    function automatic logic [7:0] fcs(input logic [23:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 23; i >= 0; i--)
            c = {c[6:0], 1'h0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
        return c;
    endfunction : fcs
    task automatic xfer(input logic [23:0] c, input int n,
                        input logic [7:0] x, output logic [31:0] r);
        logic [31:0] w;
        w = {c, fcs(c) ^ x};
        r = 32'h0;
        oe = 1'h0;
        sync_n = 1'h0;
        repeat (4) @(negedge clk);
        for (int i = 31; i > 31 - n; i--) begin
            repeat (4) @(negedge clk);
            sdi = w[i];
            r = {r[30:0], sdo};
            oe = oe | sdo_oe;
            sclk = 1'h0;
            repeat (4) @(negedge clk);
            sclk = 1'h1;
        end
        repeat (4) @(negedge clk);
        sync_n = 1'h1;
        // A released line must not keep its old level, or a late
        // sample in the device would still read the last bit as good.
        sdi = ~sdi;
        repeat (10) @(negedge clk);
    endtask : xfer
endmodule : sra_host_model

/* dv/sra_serial_regs_checker.sv */
`timescale 1ns/1ns
// ************************************************************
// Port checker for the serial register access block.
// ************************************************************
module sra_serial_regs_checker (
    input wire logic        CLK,
    input wire logic        RST_N,
    input wire logic        SYNC_N,
    input wire logic        CALIB_DONE,
    input wire logic        SDO_OE,
    input wire logic        WR_STROBE,
    input wire logic [4:0]  WR_ADDR,
    input wire logic [15:0] WR_DATA,
    input wire logic        CALIB_REFRESH_REQ,
    input wire logic        LOAD_OUTPUT_STROBE,
    input wire logic [15:0] DIGITAL_DIAG_FLAGS
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);
    a_strobe_single: assert property (WR_STROBE |=> !WR_STROBE)
        else $error("write strobe too long");
    a_strobe_sync: assert property ($rose(WR_STROBE) |->
        SYNC_N && $past(SYNC_N, 3)) else $error("write inside frame");
    a_oe_idle: assert property (SYNC_N [*6] |-> !SDO_OE)
        else $error("output driven between frames");
    a_calib_key: assert property (CALIB_REFRESH_REQ |-> WR_STROBE &&
        WR_ADDR == 5'h08 && WR_DATA == 16'hFCBA) else $error("bad key");
    a_load_addr: assert property (LOAD_OUTPUT_STROBE |->
        WR_STROBE && WR_ADDR == 5'h07) else $error("bad load strobe");
    a_no_reserved: assert property (WR_STROBE |-> !(WR_ADDR inside
        {[5'h0B:5'h0F], 5'h11, [5'h19:5'h1B], [5'h1D:5'h1F]}))
        else $error("reserved register written");
    a_pending_set: assert property (CALIB_REFRESH_REQ |->
        ##[1:2] DIGITAL_DIAG_FLAGS[15]) else $error("pending not set");
    a_pending_clr: assert property ($fell(DIGITAL_DIAG_FLAGS[15]) |->
        $past(CALIB_DONE) || $past(CALIB_DONE, 2) || $past(CALIB_DONE, 3))
        else $error("pending cleared without done");
endmodule : sra_serial_regs_checker
bind sra_serial_regs sra_serial_regs_checker sra_serial_regs_checker_i (
    .CLK(CLK), .RST_N(RST_N), .SYNC_N(SYNC_N), .CALIB_DONE(CALIB_DONE),
    .SDO_OE(SDO_OE), .WR_STROBE(WR_STROBE), .WR_ADDR(WR_ADDR),
    .WR_DATA(WR_DATA), .CALIB_REFRESH_REQ(CALIB_REFRESH_REQ),
    .LOAD_OUTPUT_STROBE(LOAD_OUTPUT_STROBE),
    .DIGITAL_DIAG_FLAGS(DIGITAL_DIAG_FLAGS));

/* dv/sra_serial_regs_tb.sv */
`timescale 1ns/1ns
// ************************************************************
// Bench for the serial register access block.
// ************************************************************
module sra_serial_regs_tb;
    logic        clk, rst_n, fault_n, osc_halted, ana, calib_done;
    logic        sclk, sync_n, sdi, sdo, sdo_oe, wr_strobe, cal_req, ld;
    logic [1:0]  ad;
    logic [4:0]  wr_addr;
    logic [15:0] dig, wr_data, flags;
    logic [31:0] r;
    int          error_cnt = 0, n_tests = 0, n_wr = 0, n_cal = 0, n_ld = 0;
    logic [23:0] bc[4] = '{24'h400000, 24'h400000, 24'hC00000, 24'h4B0000};
    int          bn[4] = '{24, 32, 32, 32};
    logic [7:0]  bx[4] = '{8'h00, 8'h01, 8'h00, 8'h00};
    logic [15:0] bf[4] = '{16'h0010, 16'h0018, 16'h001C, 16'h003C};
    logic [23:0] rc[7] = '{24'h530100, 24'h530300, 24'h400000, 24'h400000,
                           24'h530200, 24'hA00000, 24'h400000};
    logic [23:0] re[6] = '{24'hA90204, 24'hA80000, 24'hA80000, 24'h400000,
                           24'hA80000, 24'hA80000};
    sra_serial_regs sra_serial_regs_i (
        .CLK(clk), .RST_N(rst_n), .SCLK(sclk), .SYNC_N(sync_n), .SDI(sdi),
        .DEVICE_ADDR_HI(ad[1]), .DEVICE_ADDR_LO(ad[0]), .FAULT_N(fault_n),
        .OSC_HALTED(osc_halted), .DIG_FAULT_IN(dig),
        .ANALOG_FAULT_SUMMARY(ana), .CALIB_DONE(calib_done), .SDO(sdo),
        .SDO_OE(sdo_oe), .WR_STROBE(wr_strobe), .WR_ADDR(wr_addr),
        .WR_DATA(wr_data), .CALIB_REFRESH_REQ(cal_req),
        .LOAD_OUTPUT_STROBE(ld), .DIGITAL_DIAG_FLAGS(flags));
    sra_host_model sra_host_model_i (.clk(clk), .sdo(sdo), .sdo_oe(sdo_oe),
        .sclk(sclk), .sync_n(sync_n), .sdi(sdi));
    initial begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        n_wr <= n_wr + int'(wr_strobe);
        n_cal <= n_cal + int'(cal_req);
        n_ld <= n_ld + int'(ld);
    end
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test
    task automatic cmd(input logic [4:0] a, input logic [15:0] d,
                       input int n, input logic [7:0] x = 8'h00);
        sra_host_model_i.xfer({~ad[1], ad, a, d}, n, x, r);
    endtask : cmd
    initial begin
        {rst_n, fault_n, osc_halted, ana, calib_done} = 5'h08;
        ad = 2'h2;
        dig = 16'h0000;
        repeat (5) @(negedge clk);
        rst_n = 1'h1;
        @(negedge clk);
        check("flags", flags, 16'hA000);
        repeat (5000) @(negedge clk);
        cmd(sra_pkg::ADDR_KEY, 16'hFCBA, 32);
        check("key", {wr_addr, wr_data, n_cal[7:0]},
              29'h08FCBA01);
        check("pending", flags[15], 1'h1);
        calib_done = 1'h1;
        @(negedge clk);
        calib_done = 1'h0;
        repeat (4) @(negedge clk);
        check("pending", flags[15], 1'h0);
        for (int k = 0; k < 4; k++) begin
            sra_host_model_i.xfer(bc[k], bn[k], bx[k], r);
            check("errors", {flags & 16'h003C, n_wr[7:0]},
                  {bf[k], 8'h01});
        end
        dig = 16'h0002;
        cmd(sra_pkg::ADDR_DIAG_FLAGS, 16'h203E, 32);
        check("sticky", flags, 16'h0002);
        dig = 16'h0000;
        cmd(sra_pkg::ADDR_DIAG_FLAGS, 16'h0002, 32);
        check("sticky", flags, 16'h0000);
        cmd(sra_pkg::ADDR_DIAG_CONFIG, 16'h005C, 32);
        cmd(sra_pkg::ADDR_SW_LOAD, 16'h0000, 24);
        cmd(sra_pkg::ADDR_SW_LOAD, 16'h0000, 32, 8'hFF);
        sra_host_model_i.xfer(24'hA70000, 24, 8'h00, r);
        check("loads", n_ld[7:0], 8'h02);
        cmd(sra_pkg::ADDR_RB_SELECT, 16'h0010, 24);
        cmd(sra_pkg::ADDR_RB_SELECT, 16'h0009, 24);
        check("readback", r[23:0], 24'h90005C);
        cmd(sra_pkg::ADDR_NOP, 16'h0000, 24);
        check("readback", r[23:0], 24'h890204);
        fault_n = 1'h0;
        ana = 1'h1;
        for (int k = 0; k < 7; k++) begin
            sra_host_model_i.xfer(rc[k], 24, 8'h00, r);
            if (k < 6)
                check("mode word", r[23:0], re[k]);
            check("drive", sra_host_model_i.oe, k < 6);
        end
        cmd(sra_pkg::ADDR_RB_SELECT, 16'h0000, 24);
        osc_halted = 1'h1;
        repeat (4) @(negedge clk);
        cmd(sra_pkg::ADDR_NOP, 16'h0000, 24);
        check("halt code", r[23:0], 24'h07DEAD);
        stop_test();
    end
    initial begin
        repeat (60000) @(posedge clk);
        error_cnt++;
        stop_test();
    end
endmodule : sra_serial_regs_tb
